// [rtl/qdc_channel.sv]
`timescale 1ns/1ns
module qdc_channel
    import qdc_pkg::*;
#(
    parameter int RES_WIDTH  = RES_W,
    parameter int CONV_LIMIT = CONV_CYC
) (
    // Clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    // Conversion
    input  wire logic                 i_gate,
    input  wire logic                 i_inhibit,
    input  wire logic [RES_WIDTH-1:0] i_sample,
    input  wire logic                 i_overrange,
    input  wire logic                 i_conv_done,
    // Control
    input  wire logic                 i_clear,
    output logic [RES_WIDTH-1:0]      o_result,
    output logic                      o_done
);
    qdc_state_t           state_reg;
    qdc_state_t           state_next;
    logic [15:0]          cnt_reg;
    logic [RES_WIDTH-1:0] result_reg;
    logic                 finish;

    initial begin
        if (CONV_LIMIT < 1 || CONV_LIMIT > 65535 || RES_WIDTH < 1) begin
            $error("qdc_channel: bad parameters");
        end
    end

    // Done when the analog side reports, or at the worst-case bound
    assign finish = (state_reg == QDC_CONV) &&
                    (i_conv_done || cnt_reg == 16'(CONV_LIMIT - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            QDC_IDLE: if (i_gate && !i_inhibit) state_next = QDC_INTG;
            QDC_INTG: if (!i_gate) state_next = QDC_CONV;
            QDC_CONV: if (finish) state_next = QDC_IDLE;
            default:  state_next = QDC_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg  <= QDC_IDLE;
            cnt_reg    <= 16'h0000;
            result_reg <= RES_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == QDC_CONV) ? cnt_reg + 16'h0001 : 16'h0000;
            if (finish) begin
                result_reg <= i_overrange ? {RES_WIDTH{1'b1}} : i_sample;
            end else if (i_clear) begin
                result_reg <= RES_RESET;
            end
        end
    end

    assign o_result = result_reg;
    assign o_done   = finish && i_ce;

    a_conv_bound: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state_reg == QDC_CONV) |-> cnt_reg < 16'(CONV_LIMIT))
        else $error("conversion overran its bound");
    a_ovr_ones: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (finish && i_ce && i_overrange) |=> result_reg == {RES_WIDTH{1'b1}})
        else $error("overrange did not saturate");
endmodule

// [rtl/qdc_ctrl.sv]
`timescale 1ns/1ns
module qdc_ctrl
    import qdc_pkg::*;
#(
    parameter int CONV_LIMIT = CONV_CYC,
    parameter int TEST_GATE  = TGATE_CYC
) (
    // Clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_ce,
    // Dataway command
    input  wire qdc_cmd_t                i_cmd,
    input  wire logic                    i_inhibit,
    input  wire logic                    i_init_z,
    input  wire logic                    i_clear_c,
    // Dataway response
    output logic [RES_W-1:0]             o_read_data,
    output logic                         o_q,
    output logic                         o_x,
    output logic                         o_lam,
    // Front end
    input  wire logic [NUM_CH-1:0]       i_channel_gate_input,
    input  wire logic [NUM_CH*RES_W-1:0] i_sample,
    input  wire logic [NUM_CH-1:0]       i_overrange,
    input  wire logic [NUM_CH-1:0]       i_conv_done,
    output logic [NUM_CH-1:0]            o_channel_gate
);
    logic [NUM_CH-1:0]       flags_reg;
    logic [NUM_CH-1:0]       flags_next;
    logic                    lam_en_reg;
    logic [3:0]              tgate_reg;
    logic [RES_W-1:0]        rdata_reg;
    logic                    q_reg;
    logic                    x_reg;
    logic [NUM_CH*RES_W-1:0] results;
    logic [NUM_CH-1:0]       done;
    logic [NUM_CH-1:0]       ch_sel;
    logic [NUM_CH-1:0]       res_clear;
    logic [NUM_CH-1:0]       flag_clear;
    logic                    cmd_on;
    logic                    a_chan;
    logic                    a_mod;
    logic                    do_read;
    logic                    do_stat;
    logic                    do_rdclr;
    logic                    do_tlam;
    logic                    do_clr;
    logic                    do_clam;
    logic                    do_dis;
    logic                    do_test;
    logic                    do_ena;
    logic                    listed;
    logic                    req_level;
    logic                    test_gate;
    logic [RES_W-1:0]        sel_result;

    initial begin
        if (TEST_GATE < 1 || TEST_GATE > 15 || CONV_LIMIT < 1) begin
            $error("qdc_ctrl: bad parameters");
        end
    end

    // Command decode, qualified by station and strobe
    assign cmd_on   = i_cmd.station && i_cmd.strobe;
    assign a_chan   = (i_cmd.subaddr[3:2] == 2'b00);
    assign a_mod    = (i_cmd.subaddr == A_MODULE);
    assign do_read  = cmd_on && i_cmd.func == F_READ && a_chan;
    assign do_stat  = cmd_on && i_cmd.func == F_RD_STAT && a_mod;
    assign do_rdclr = cmd_on && i_cmd.func == F_RD_CLR && a_chan;
    assign do_tlam  = cmd_on && i_cmd.func == F_TEST_LAM && a_mod;
    assign do_clr   = cmd_on && i_cmd.func == F_CLR_RES && a_chan;
    assign do_clam  = cmd_on && i_cmd.func == F_CLR_LAM && a_chan;
    assign do_dis   = cmd_on && i_cmd.func == F_DIS_LAM && a_mod;
    assign do_test  = cmd_on && i_cmd.func == F_TEST_ALL;
    assign do_ena   = cmd_on && i_cmd.func == F_ENA_LAM && a_mod;
    assign listed   = do_read | do_stat | do_rdclr | do_tlam | do_clr |
                      do_clam | do_dis | do_test | do_ena;

    assign ch_sel     = NUM_CH'(1) << i_cmd.subaddr[1:0];
    assign res_clear  = ({NUM_CH{do_rdclr | do_clr}} & ch_sel) |
                        {NUM_CH{i_init_z | i_clear_c}};
    assign flag_clear = ({NUM_CH{do_clam}} & ch_sel) |
                        {NUM_CH{i_init_z | i_clear_c}};
    // A new completion wins over a clear in the same cycle
    assign flags_next = (flags_reg & ~flag_clear) | done;
    assign req_level  = lam_en_reg && (|flags_reg);
    assign test_gate  = (tgate_reg != 4'h0);
    assign sel_result = results[i_cmd.subaddr[1:0]*RES_W +: RES_W];

    // Test pulse shares each channel's gate path
    assign o_channel_gate = i_channel_gate_input | {NUM_CH{test_gate}};

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            qdc_channel #(
                .RES_WIDTH  (RES_W),
                .CONV_LIMIT (CONV_LIMIT)
            ) u_ch (
                .i_core_clk  (i_core_clk),
                .i_rst_n     (i_rst_n),
                .i_ce        (i_ce),
                .i_gate      (o_channel_gate[g]),
                .i_inhibit   (i_inhibit),
                .i_sample    (i_sample[g*RES_W +: RES_W]),
                .i_overrange (i_overrange[g]),
                .i_conv_done (i_conv_done[g]),
                .i_clear     (res_clear[g]),
                .o_result    (results[g*RES_W +: RES_W]),
                .o_done      (done[g])
            );
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_reg  <= 4'h0;
            lam_en_reg <= LAM_EN_RESET;
            tgate_reg  <= 4'h0;
        end else if (i_ce) begin
            flags_reg <= flags_next;
            if (i_init_z || do_dis) begin
                lam_en_reg <= 1'b0;
            end else if (do_ena) begin
                lam_en_reg <= 1'b1;
            end
            if (do_test) begin
                tgate_reg <= 4'(TEST_GATE);
            end else if (test_gate) begin
                tgate_reg <= tgate_reg - 4'h1;
            end
        end
    end

    // Response registered one cycle after the strobed command
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 10'h000;
            q_reg     <= 1'b0;
            x_reg     <= 1'b0;
        end else if (i_ce) begin
            x_reg <= listed;
            q_reg <= do_tlam ? req_level : listed;
            if (do_read || do_rdclr) begin
                rdata_reg <= sel_result;
            end else if (do_stat) begin
                rdata_reg <= {6'h00, flags_reg};
            end else begin
                rdata_reg <= 10'h000;
            end
        end
    end

    assign o_read_data = rdata_reg;
    assign o_q         = q_reg;
    assign o_x         = x_reg;
    assign o_lam       = req_level;

    a_lam_gating: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && lam_en_reg && done != 4'h0 && !i_init_z && !do_dis) |=> o_lam)
        else $error("L line missed an enabled completion");
    a_done_sets: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && done[0]) |=> flags_reg[0])
        else $error("done did not set its flag");
    a_station_req: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !i_cmd.station) |=> !o_x)
        else $error("X without station");
    a_unlisted_nox: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && cmd_on && !listed) |=> (!o_x && !o_q))
        else $error("X for unlisted command");
    a_tlam_q: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && do_tlam) |=> (o_q == $past(req_level) && o_x))
        else $error("test request Q wrong");
    a_test_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && do_test && TEST_GATE == 4) |=> (&o_channel_gate) [*4])
        else $error("test gate too short");
    a_z_disables: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_init_z && done == 4'h0) |=> (!lam_en_reg && flags_reg == 4'h0))
        else $error("Z did not clear");
    a_stat_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && do_stat) |=> o_read_data == {6'h00, $past(flags_reg)})
        else $error("status read wrong");
    a_rdclr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && do_rdclr && done == 4'h0) |=> o_read_data == $past(sel_result))
        else $error("read and clear data wrong");
endmodule

// [rtl/qdc_pkg.sv]
// Function
// - Four channels, each holding a 10-bit result at subaddress 0 to 3.
// - A channel integrates during its gate; gate end starts conversion.
// - Four-bit status register, one independent done flag per channel.
// - Finished conversion sets only that channel's done flag.
// - L line is OR of flags while enable latch is set.
// - Read places addressed 10-bit result on R1 to R10.
// - Overrange forces every result bit to one.
// - F25 fires a 40 to 50 ns gate on all channels.
// - Test command accepted with any subaddress 0 to 15.
// - Commands execute only while station line is asserted.
// - F0 A0-3 reads selected result without changing it.
// - F1 A12 reads status, channel 0 on R1 upward.
// - F2 A0-3 reads selected result then clears it.
// - F8 A12 answers Q with request level, no state change.
// - F9 A0-3 clears only the selected result.
// - F10 A0-3 clears only the selected flag; F24 A12 disables, F26 A12 enables latch.
// - Inhibit blocks gate acceptance on all channels.
// - Z clears registers and disables requests; C clears registers only.
// - Q and X asserted for listed commands; F8 Q follows request.
// - Conversion finishes within 20.5 us after gate ends.
package qdc_pkg;
    localparam int          NUM_CH        = 4;
    localparam int          RES_W         = 10;
    localparam int          CLK_MHZ       = 100;
    localparam int          CONV_MAX_NS   = 20500;
    localparam int          CONV_CYC      = (CONV_MAX_NS * CLK_MHZ) / 1000;
    localparam int          TGATE_MIN_NS  = 40;
    localparam int          TGATE_CYC     = (TGATE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0]  F_READ        = 5'h00;
    localparam logic [4:0]  F_RD_STAT     = 5'h01;
    localparam logic [4:0]  F_RD_CLR      = 5'h02;
    localparam logic [4:0]  F_TEST_LAM    = 5'h08;
    localparam logic [4:0]  F_CLR_RES     = 5'h09;
    localparam logic [4:0]  F_CLR_LAM     = 5'h0a;
    localparam logic [4:0]  F_DIS_LAM     = 5'h18;
    localparam logic [4:0]  F_TEST_ALL    = 5'h19;
    localparam logic [4:0]  F_ENA_LAM     = 5'h1a;
    localparam logic [3:0]  A_MODULE      = 4'hc;
    localparam logic [9:0]  RES_RESET     = 10'h000;
    localparam logic        LAM_EN_RESET  = 1'b0;

    typedef struct packed {
        logic       station;
        logic       strobe;
        logic [4:0] func;
        logic [3:0] subaddr;
    } qdc_cmd_t;

    typedef enum logic [1:0] {
        QDC_IDLE = 2'b00,
        QDC_INTG = 2'b01,
        QDC_CONV = 2'b10
    } qdc_state_t;
endpackage

// [tb/qdc_dataway_ctl.sv]
`timescale 1ns/1ns
module qdc_dataway_ctl
    import qdc_pkg::*;
(
    // Dataway
    input  wire logic             i_core_clk,
    output qdc_cmd_t              o_cmd,
    input  wire logic [RES_W-1:0] i_read_data,
    input  wire logic             i_q,
    input  wire logic             i_x
);
    initial o_cmd = '{station: 1'b0, strobe: 1'b0, func: 5'h1f, subaddr: 4'hf};

    // One cycle per command; idle lines show the inverse of the last code
    task automatic command(input logic st, input logic [4:0] f, input logic [3:0] a,
                           output logic [RES_W-1:0] d, output logic q, output logic x);
        @(posedge i_core_clk);
        #1;
        o_cmd = '{station: st, strobe: 1'b1, func: f, subaddr: a};
        @(posedge i_core_clk);
        #1;
        o_cmd = '{station: 1'b0, strobe: 1'b0, func: ~f, subaddr: ~a};
        d = i_read_data;
        q = i_q;
        x = i_x;
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import qdc_pkg::*;
    localparam int CONV_SIM = 20;
    logic                    clk;
    logic                    ce;
    logic                    i_rst_n;
    logic                    inh;
    logic                    z_line;
    logic                    c_line;
    logic [NUM_CH-1:0]       gate;
    logic [NUM_CH-1:0]       ovr;
    logic [NUM_CH-1:0]       cdone;
    logic [NUM_CH-1:0]       channel_gate_input;
    logic [NUM_CH*RES_W-1:0] sample;
    qdc_cmd_t                cmd_bus;
    logic [RES_W-1:0]        rdata;
    logic [RES_W-1:0]        rd;
    logic                    q_line;
    logic                    x_line;
    logic                    lam;
    logic                    q;
    logic                    x;
    int                      num_errors;
    int                      checks_done;

    qdc_ctrl #(.CONV_LIMIT(CONV_SIM), .TEST_GATE(4)) dut (
        .i_core_clk(clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_cmd(cmd_bus),
        .i_inhibit(inh), .i_init_z(z_line), .i_clear_c(c_line),
        .o_read_data(rdata), .o_q(q_line), .o_x(x_line), .o_lam(lam),
        .i_channel_gate_input(gate), .i_sample(sample), .i_overrange(ovr),
        .i_conv_done(cdone), .o_channel_gate(channel_gate_input));
    qdc_dataway_ctl ctl (.i_core_clk(clk), .o_cmd(cmd_bus), .i_read_data(rdata),
        .i_q(q_line), .i_x(x_line));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic cmd(input logic [4:0] f, input logic [3:0] a);
        ctl.command(1'b1, f, a, rd, q, x);
    endtask

    // Gate, then a finish pulse from the analog side
    task automatic conv(input int ch, input logic [RES_W-1:0] v, input logic ov);
        @(posedge clk);
        #1 gate[ch] = 1'b1;
        repeat (3) @(posedge clk);
        #1 gate[ch] = 1'b0;
        sample[ch*RES_W +: RES_W] = v;
        ovr[ch] = ov;
        @(posedge clk);
        #1 cdone[ch] = 1'b1;
        @(posedge clk);
        #1 cdone[ch] = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Drives the line itself; a task argument copy would never reach the design
    task automatic pulse(input bit use_z);
        @(posedge clk);
        #1;
        if (use_z) begin
            z_line = 1'b1;
        end else begin
            c_line = 1'b1;
        end
        @(posedge clk);
        #1;
        {z_line, c_line} = 2'b00;
    endtask

    task automatic t_read;
        conv(1, 10'h2a5, 1'b0);
        cmd(F_RD_STAT, A_MODULE);
        check(rd, 16'h2, "status after ch1");
        check({q, x}, 16'h3, "q x status");
        check(lam, 16'h0, "lam while disabled");
        cmd(F_READ, 4'h1);
        check(rd, 16'h2a5, "read ch1");
        cmd(F_READ, 4'h1);
        check(rd, 16'h2a5, "reread ch1");
    endtask

    task automatic t_ovr;
        conv(2, 10'h155, 1'b1);
        cmd(F_RD_CLR, 4'h2);
        check(rd, 16'h3ff, "overrange ch2");
        cmd(F_READ, 4'h2);
        check(rd, 16'h0, "ch2 after read clear");
        conv(3, 10'h0f0, 1'b0);
        cmd(F_CLR_RES, 4'h3);
        cmd(F_READ, 4'h3);
        check(rd, 16'h0, "ch3 cleared");
        cmd(F_READ, 4'h1);
        check(rd, 16'h2a5, "ch1 kept");
    endtask

    task automatic t_lam;
        cmd(F_ENA_LAM, A_MODULE);
        check(lam, 16'h1, "lam enabled");
        cmd(F_TEST_LAM, A_MODULE);
        check({q, x}, 16'h3, "test lam high");
        for (int i = 1; i < NUM_CH; i++) begin
            cmd(F_CLR_LAM, 4'(i));
            cmd(F_RD_STAT, A_MODULE);
            check(rd, 16'(4'(4'he << i)), "flag clear one");
        end
        cmd(F_TEST_LAM, A_MODULE);
        check({q, x, lam}, 16'h2, "test lam low");
        cmd(F_DIS_LAM, A_MODULE);
        conv(0, 10'h011, 1'b0);
        check(lam, 16'h0, "lam disabled");
        cmd(F_ENA_LAM, A_MODULE);
        check(lam, 16'h1, "lam reenabled");
    endtask

    task automatic t_test_all;
        cmd(F_TEST_ALL, 4'hf);
        check({channel_gate_input, q, x}, 16'h3f, "test gate on");
        repeat (4) @(posedge clk);
        #1 check(channel_gate_input, 16'h0, "test gate off");
        repeat (CONV_SIM + 3) @(posedge clk);
        cmd(F_RD_STAT, A_MODULE);
        check(rd, 16'hf, "all channels done");
    endtask

    task automatic t_clear;
        pulse(1'b0);
        cmd(F_RD_STAT, A_MODULE);
        check({rd, lam}, 16'h0, "after clear");
        conv(1, 10'h07e, 1'b0);
        check(lam, 16'h1, "enable kept");
        pulse(1'b1);
        cmd(F_READ, 4'h1);
        check({rd, lam}, 16'h0, "after init");
        conv(1, 10'h07e, 1'b0);
        check(lam, 16'h0, "init disables");
        cmd(F_CLR_LAM, 4'h1);
        inh = 1'b1;
        conv(0, 10'h033, 1'b0);
        inh = 1'b0;
        cmd(F_RD_STAT, A_MODULE);
        check(rd, 16'h0, "inhibit blocks gate");
    endtask

    task automatic t_refuse;
        conv(2, 10'h1c3, 1'b0);
        ctl.command(1'b0, F_CLR_RES, 4'h2, rd, q, x);
        ce = 1'b0;
        cmd(F_CLR_RES, 4'h2);
        ce = 1'b1;
        check({q, x}, 16'h0, "frozen by enable");
        cmd(F_RD_STAT, 4'h0);
        check({q, x}, 16'h0, "bad subaddress");
        cmd(F_CLR_LAM, A_MODULE);
        check({q, x}, 16'h0, "clear flag a12");
        cmd(F_READ, 4'h2);
        check(rd, 16'h1c3, "no station no clear");
        cmd(F_RD_STAT, A_MODULE);
        check(rd, 16'h4, "refused kept flags");
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        close_out;
    end

    initial begin
        {i_rst_n, inh, z_line, c_line, gate, ovr, cdone, sample} = '0;
        ce = 1'b1;
        num_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        #1 i_rst_n = 1'b1;
        t_read;
        t_ovr;
        t_lam;
        t_test_all;
        t_clear;
        t_refuse;
        close_out;
    end
endmodule
